// ===== include/rspc_params.svh
`ifndef RSPC_PARAMS_SVH
`define RSPC_PARAMS_SVH
`define RSPC_CTRL_OFFSET    8'h08
`define RSPC_CTRL_RESET     32'h0024_0002
`define RSPC_CTRL_WMASK     32'h03BF_766E
`define RSPC_B_SR_WAKE_REQ  25
`define RSPC_B_SR_WAKE      24
`define RSPC_B_SR_SLEEP     23
`define RSPC_B_SR_RETAIN    21
`define RSPC_B_BK0_WAKE     20
`define RSPC_B_BK0_SLEEP    19
`define RSPC_B_MR_RETAIN    18
`define RSPC_B_MR_AUTO_DS   17
`define RSPC_B_REG_RET_OFF  16
`define RSPC_B_BK3_WAKE     14
`define RSPC_B_BK3_SLEEP    13
`define RSPC_B_BK2_WAKE     10
`define RSPC_B_BK2_SLEEP    9
`define RSPC_B_BK1_WAKE     6
`define RSPC_B_BK1_SLEEP    5
`define RSPC_B_MR_WAKE      3
`define RSPC_B_MR_SLEEP     2
`define RSPC_B_MR_PERMIT    1
`endif

// ===== include/rspc_pkg.sv
package rspc_pkg;
  typedef enum logic [1:0] {
    RSPC_REQ_IDLE = 2'b01,
    RSPC_REQ_BUSY = 2'b10
  } rspc_req_state_e;
endpackage : rspc_pkg

// ===== verification/radio_sram_power_control_bench.sv
`timescale 1ns/1ps
module radio_sram_power_control_bench;
  logic        ref_clk, nrst, standby_wake, reg_wr, reg_rd, slow;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [11:0] cmd_pulse, cmd_ack;
  logic        sr_req, sr_ret, mr_ret, mr_ads, ret_off, permit;
  logic [31:0] cw, pw;
  logic [5:0]  lv;
  int          failures, n_compared;
  int          cmd_bit [12] = '{24, 23, 20, 19, 6, 5, 10, 9, 14, 13, 3, 2};

  assign pw = 32'(cmd_pulse);
  assign lv = {sr_req, sr_ret, mr_ret, mr_ads, ret_off, permit};

  rspc_power_ctrl u_rspc_power_ctrl (
    .ref_clk(ref_clk), .nrst(nrst), .standby_wake(standby_wake),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmd_pulse(cmd_pulse), .cmd_ack(cmd_ack),
    .short_radio_wake_request(sr_req), .short_radio_mem_retain(sr_ret),
    .main_radio_mem_retain(mr_ret), .main_radio_auto_deepsleep(mr_ads),
    .register_retain_off(ret_off), .main_radio_gating_permit(permit)
  );

  rspc_domain_model u_rspc_domain_model (
    .ref_clk(ref_clk), .nrst(nrst), .cmd_pulse(cmd_pulse),
    .cmd_ack(cmd_ack), .slow(slow)
  );

  task automatic summarize();
    if (failures == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask : rdc

  task automatic wait_ack(input int i);
    int n;
    n = 0;
    while (cmd_ack[i] !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (cmd_ack[i] !== 1'b1) begin
      failures++;
      summarize();
    end
  endtask : wait_ack

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  initial begin
    failures = 0;
    n_compared = 0;
    nrst = 1'b0;
    standby_wake = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    slow = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    rdc(8'h08, 32'h0024_0002);
    rdc(8'h0C, 32'h0000_0000);
    wr(8'h08, 32'h0227_0002);
    rdc(8'h08, 32'h0227_0002);
    check(32'(lv), 32'h0000_003F);
    wr(8'h08, 32'h0000_0002);
    check(32'(lv), 32'h0000_0001);
    for (int i = 0; i < 12; i++) begin
      slow <= (i < 6);
      cw = 32'h0000_0002 | (32'h0000_0001 << cmd_bit[i]);
      wr(8'h08, cw);
      check(pw, 32'h0000_0001 << i);
      if (i < 6) rdc(8'h08, cw);
      wait_ack(i);
      rdc(8'h08, 32'h0000_0002);
    end
    slow <= 1'b0;
    // the main domain is assumed reset and its oscillator running around this
    wr(8'h08, 32'h0000_0000);
    check(32'(cmd_pulse), 32'h0000_0400);
    wait_ack(10);
    wr(8'h08, 32'h0000_000C);
    check(32'(cmd_pulse), 32'h0000_0000);
    rdc(8'h08, 32'h0000_0000);
    wr(8'h08, 32'h0227_0002);
    @(posedge ref_clk);
    standby_wake <= 1'b1;
    @(posedge ref_clk);
    standby_wake <= 1'b0;
    rdc(8'h08, 32'h0024_0002);
    check(32'(lv), 32'h0000_0019);
    summarize();
  end
endmodule : radio_sram_power_control_bench

// ===== verification/rspc_domain_model.sv
`timescale 1ns/1ps
// far-side power domains: accept each command pulse with a one-cycle ack
module rspc_domain_model (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // command handshake
  input  wire logic [11:0] cmd_pulse,
  output logic      [11:0] cmd_ack,
  // answer pace
  input  wire logic        slow
);
  logic [11:0] dly_ff [6];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dly_ff  <= '{default: '0};
      cmd_ack <= 12'h000;
    end else begin
      dly_ff[0] <= cmd_pulse;
      for (int k = 1; k < 6; k++) begin
        dly_ff[k] <= dly_ff[k-1];
      end
      // slow pace keeps the request pending long enough to read it back
      cmd_ack <= slow ? dly_ff[5] : cmd_pulse;
    end
  end
endmodule : rspc_domain_model

// ===== verilog/rspc_power_ctrl.sv
// Contract
// - register resets on standby wake too
// - bit 25 radio wake request, resets zero
// - bit 24 wakes radio, self-clears
// - bit 23 sleeps radio, self-clears
// - bit 21 selects radio memory retention
// - bits 20/19 wake/sleep bank 0
// - bits 14/13 wake/sleep bank 3
// - bits 10/9 wake/sleep bank 2
// - bits 6/5 wake/sleep bank 1
// - bit 18 selects main memory retention
// - bit 17 runs auto deep-sleep flow
// - bit 16 disables register retention
// - bit 3 wakes main only if permitted
// - permit falling edge wakes main
// - bit 2 sleeps main only if permitted
// - bit 1 permits gating, resets one
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "rspc_params.svh"
module rspc_power_ctrl #(
  parameter int NUM_CMD = 12
) (
  // clock and resets
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        standby_wake,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // command pulses, index order: sr wake, sr sleep, bk0 w/s, bk1 w/s,
  // bk2 w/s, bk3 w/s, main wake, main sleep
  output logic [11:0]      cmd_pulse,
  input  wire logic [11:0] cmd_ack,
  // levels to the domains
  output logic             short_radio_wake_request,
  output logic             short_radio_mem_retain,
  output logic             main_radio_mem_retain,
  output logic             main_radio_auto_deepsleep,
  output logic             register_retain_off,
  output logic             main_radio_gating_permit
);
  if (NUM_CMD != 12) begin : g_bad_num_cmd
    $error("NUM_CMD must be 12");
  end

  logic        wr_hit;
  logic [31:0] wv;
  logic [11:0] set_cmd;
  logic [11:0] pend;
  logic        permit_fall;
  logic        main_wake_set;
  logic [31:0] ctrl_view;

  assign wr_hit = reg_wr && (reg_addr == `RSPC_CTRL_OFFSET);
  assign wv     = reg_wdata & `RSPC_CTRL_WMASK;

  function automatic logic wbit(input logic [31:0] d, input int b);
    return d[b];
  endfunction : wbit

  // permit drops 1->0 by software write: also a wake of the main domain
  assign permit_fall = wr_hit && main_radio_gating_permit &&
                       !wbit(wv, `RSPC_B_MR_PERMIT);
  // wake/sleep honoured only while gating was permitted
  assign main_wake_set = (wr_hit && main_radio_gating_permit &&
                          wbit(wv, `RSPC_B_MR_WAKE)) || permit_fall;

  always_comb begin
    set_cmd     = '0;
    set_cmd[0]  = wr_hit && wbit(wv, `RSPC_B_SR_WAKE);
    set_cmd[1]  = wr_hit && wbit(wv, `RSPC_B_SR_SLEEP);
    set_cmd[2]  = wr_hit && wbit(wv, `RSPC_B_BK0_WAKE);
    set_cmd[3]  = wr_hit && wbit(wv, `RSPC_B_BK0_SLEEP);
    set_cmd[4]  = wr_hit && wbit(wv, `RSPC_B_BK1_WAKE);
    set_cmd[5]  = wr_hit && wbit(wv, `RSPC_B_BK1_SLEEP);
    set_cmd[6]  = wr_hit && wbit(wv, `RSPC_B_BK2_WAKE);
    set_cmd[7]  = wr_hit && wbit(wv, `RSPC_B_BK2_SLEEP);
    set_cmd[8]  = wr_hit && wbit(wv, `RSPC_B_BK3_WAKE);
    set_cmd[9]  = wr_hit && wbit(wv, `RSPC_B_BK3_SLEEP);
    set_cmd[10] = main_wake_set;
    set_cmd[11] = wr_hit && main_radio_gating_permit &&
                  wbit(wv, `RSPC_B_MR_SLEEP);
  end

  // standby wake acts as a synchronous reset of the whole register
  logic reg_clr;
  assign reg_clr = standby_wake;

  genvar gi;
  generate
    for (gi = 0; gi < 12; gi++) begin : g_cmd
      rspc_req_chan u_chan (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .set_req   (set_cmd[gi] && !reg_clr),
        .pending   (pend[gi]),
        .req_pulse (cmd_pulse[gi]),
        // standby clear acts as a forced ack: no reset made of logic
        .ack       (cmd_ack[gi] || reg_clr)
      );
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      short_radio_wake_request  <= 1'b0;
      short_radio_mem_retain    <= 1'b1;
      main_radio_mem_retain     <= 1'b1;
      main_radio_auto_deepsleep <= 1'b0;
      register_retain_off       <= 1'b0;
      main_radio_gating_permit  <= 1'b1;
    end else if (reg_clr) begin
      short_radio_wake_request  <= 1'b0;
      short_radio_mem_retain    <= 1'b1;
      main_radio_mem_retain     <= 1'b1;
      main_radio_auto_deepsleep <= 1'b0;
      register_retain_off       <= 1'b0;
      main_radio_gating_permit  <= 1'b1;
    end else if (wr_hit) begin
      short_radio_wake_request  <= wbit(wv, `RSPC_B_SR_WAKE_REQ);
      short_radio_mem_retain    <= wbit(wv, `RSPC_B_SR_RETAIN);
      main_radio_mem_retain     <= wbit(wv, `RSPC_B_MR_RETAIN);
      main_radio_auto_deepsleep <= wbit(wv, `RSPC_B_MR_AUTO_DS);
      register_retain_off       <= wbit(wv, `RSPC_B_REG_RET_OFF);
      main_radio_gating_permit  <= wbit(wv, `RSPC_B_MR_PERMIT);
    end
  end

  always_comb begin
    ctrl_view = '0;
    ctrl_view[`RSPC_B_SR_WAKE_REQ] = short_radio_wake_request;
    ctrl_view[`RSPC_B_SR_WAKE]     = pend[0];
    ctrl_view[`RSPC_B_SR_SLEEP]    = pend[1];
    ctrl_view[`RSPC_B_SR_RETAIN]   = short_radio_mem_retain;
    ctrl_view[`RSPC_B_BK0_WAKE]    = pend[2];
    ctrl_view[`RSPC_B_BK0_SLEEP]   = pend[3];
    ctrl_view[`RSPC_B_MR_RETAIN]   = main_radio_mem_retain;
    ctrl_view[`RSPC_B_MR_AUTO_DS]  = main_radio_auto_deepsleep;
    ctrl_view[`RSPC_B_REG_RET_OFF] = register_retain_off;
    ctrl_view[`RSPC_B_BK3_WAKE]    = pend[8];
    ctrl_view[`RSPC_B_BK3_SLEEP]   = pend[9];
    ctrl_view[`RSPC_B_BK2_WAKE]    = pend[6];
    ctrl_view[`RSPC_B_BK2_SLEEP]   = pend[7];
    ctrl_view[`RSPC_B_BK1_WAKE]    = pend[4];
    ctrl_view[`RSPC_B_BK1_SLEEP]   = pend[5];
    ctrl_view[`RSPC_B_MR_WAKE]     = pend[10];
    ctrl_view[`RSPC_B_MR_SLEEP]    = pend[11];
    ctrl_view[`RSPC_B_MR_PERMIT]   = main_radio_gating_permit;
  end

  // unmapped reads return zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd && reg_addr == `RSPC_CTRL_OFFSET) begin
      reg_rdata <= ctrl_view;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  property p_wake_gated;
    @(posedge ref_clk) disable iff (!nrst)
      (wr_hit && !main_radio_gating_permit && !reg_clr && !pend[10])
        |=> !cmd_pulse[10];
  endproperty
  a_wake_gated: assert property (p_wake_gated)
    else $error("main wake without permit");

  property p_sleep_gated;
    @(posedge ref_clk) disable iff (!nrst)
      (wr_hit && !main_radio_gating_permit && !reg_clr && !pend[11])
        |=> !cmd_pulse[11];
  endproperty
  a_sleep_gated: assert property (p_sleep_gated)
    else $error("main sleep without permit");

  property p_fall_wakes;
    @(posedge ref_clk) disable iff (!nrst)
      (permit_fall && !pend[10] && !reg_clr) |=> cmd_pulse[10] && pend[10];
  endproperty
  a_fall_wakes: assert property (p_fall_wakes)
    else $error("permit drop did not wake main");

  property p_standby_reset;
    @(posedge ref_clk) disable iff (!nrst)
      standby_wake |=> main_radio_gating_permit && main_radio_mem_retain
        && short_radio_mem_retain
        && !short_radio_wake_request && (pend == 12'h000);
  endproperty
  a_standby_reset: assert property (p_standby_reset)
    else $error("standby wake did not reset");

  property p_bank0_wake;
    @(posedge ref_clk) disable iff (!nrst)
      (set_cmd[2] && !pend[2] && !reg_clr) |=> cmd_pulse[2] ##1 !cmd_pulse[2];
  endproperty
  a_bank0_wake: assert property (p_bank0_wake)
    else $error("bank0 wake pulse wrong");

  property p_radio_wake;
    @(posedge ref_clk) disable iff (!nrst)
      (set_cmd[0] && !pend[0] && !reg_clr) |=> pend[0] && cmd_pulse[0];
  endproperty
  a_radio_wake: assert property (p_radio_wake)
    else $error("radio wake not issued");

  property p_radio_sleep;
    @(posedge ref_clk) disable iff (!nrst)
      (set_cmd[1] && !pend[1] && !reg_clr) |=> pend[1] && cmd_pulse[1];
  endproperty
  a_radio_sleep: assert property (p_radio_sleep)
    else $error("radio sleep not issued");

  property p_readback;
    @(posedge ref_clk) disable iff (!nrst)
      (reg_rd && reg_addr == `RSPC_CTRL_OFFSET)
        |=> reg_rdata[`RSPC_B_MR_PERMIT] == $past(main_radio_gating_permit);
  endproperty
  a_readback: assert property (p_readback)
    else $error("permit readback wrong");

  property p_wake_req;
    @(posedge ref_clk) disable iff (!nrst)
      (wr_hit && !reg_clr)
        |=> short_radio_wake_request == $past(reg_wdata[`RSPC_B_SR_WAKE_REQ]);
  endproperty
  a_wake_req: assert property (p_wake_req)
    else $error("wake request bit not written");

  property p_sr_retain;
    @(posedge ref_clk) disable iff (!nrst)
      (wr_hit && !reg_clr)
        |=> short_radio_mem_retain == $past(reg_wdata[`RSPC_B_SR_RETAIN]);
  endproperty
  a_sr_retain: assert property (p_sr_retain)
    else $error("radio retention bit not written");

  property p_mr_retain;
    @(posedge ref_clk) disable iff (!nrst)
      (wr_hit && !reg_clr)
        |=> main_radio_mem_retain == $past(reg_wdata[`RSPC_B_MR_RETAIN]);
  endproperty
  a_mr_retain: assert property (p_mr_retain)
    else $error("main retention bit not written");

  property p_auto_ds;
    @(posedge ref_clk) disable iff (!nrst)
      (wr_hit && !reg_clr)
        |=> main_radio_auto_deepsleep == $past(reg_wdata[`RSPC_B_MR_AUTO_DS]);
  endproperty
  a_auto_ds: assert property (p_auto_ds)
    else $error("auto deep-sleep bit not written");

  property p_ret_off;
    @(posedge ref_clk) disable iff (!nrst)
      (wr_hit && !reg_clr)
        |=> register_retain_off == $past(reg_wdata[`RSPC_B_REG_RET_OFF]);
  endproperty
  a_ret_off: assert property (p_ret_off)
    else $error("retention disable bit not written");

  property p_permit_wr;
    @(posedge ref_clk) disable iff (!nrst)
      (wr_hit && !reg_clr)
        |=> main_radio_gating_permit == $past(reg_wdata[`RSPC_B_MR_PERMIT]);
  endproperty
  a_permit_wr: assert property (p_permit_wr)
    else $error("permit bit not written");

  property p_bank1_wake;
    @(posedge ref_clk) disable iff (!nrst)
      (set_cmd[4] && !pend[4] && !reg_clr) |=> cmd_pulse[4] && pend[4];
  endproperty
  a_bank1_wake: assert property (p_bank1_wake)
    else $error("bank1 wake not issued");

  property p_bank2_sleep;
    @(posedge ref_clk) disable iff (!nrst)
      (set_cmd[7] && !pend[7] && !reg_clr) |=> cmd_pulse[7] && pend[7];
  endproperty
  a_bank2_sleep: assert property (p_bank2_sleep)
    else $error("bank2 sleep not issued");

  property p_bank3_wake;
    @(posedge ref_clk) disable iff (!nrst)
      (set_cmd[8] && !pend[8] && !reg_clr) |=> cmd_pulse[8] && pend[8];
  endproperty
  a_bank3_wake: assert property (p_bank3_wake)
    else $error("bank3 wake not issued");

  property p_main_wake;
    @(posedge ref_clk) disable iff (!nrst)
      (wr_hit && main_radio_gating_permit && reg_wdata[`RSPC_B_MR_WAKE]
        && !pend[10] && !reg_clr) |=> cmd_pulse[10] && pend[10];
  endproperty
  a_main_wake: assert property (p_main_wake)
    else $error("permitted main wake not issued");

  property p_pend_holds;
    @(posedge ref_clk) disable iff (!nrst)
      !reg_clr |=> (($past(pend) & ~$past(cmd_ack) & ~pend) == 12'h000);
  endproperty
  a_pend_holds: assert property (p_pend_holds)
    else $error("pending bit dropped without ack");

  property p_ack_drops;
    @(posedge ref_clk) disable iff (!nrst)
      ((pend & cmd_ack) != 12'h000)
        |=> ((pend & $past(pend & cmd_ack)) == 12'h000);
  endproperty
  a_ack_drops: assert property (p_ack_drops)
    else $error("pending bit kept after ack");
endmodule : rspc_power_ctrl

// ===== verilog/rspc_req_chan.sv
`timescale 1ns/1ps
// one self-clearing request: pulse to the domain, hold until acknowledged
module rspc_req_chan (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic nrst,
  // request side
  input  wire logic set_req,
  output logic      pending,
  // domain side
  output logic      req_pulse,
  input  wire logic ack
);
  rspc_pkg::rspc_req_state_e state_ff;
  rspc_pkg::rspc_req_state_e nxt_state;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      rspc_pkg::RSPC_REQ_IDLE: begin
        if (set_req) nxt_state = rspc_pkg::RSPC_REQ_BUSY;
      end
      rspc_pkg::RSPC_REQ_BUSY: begin
        if (ack) nxt_state = rspc_pkg::RSPC_REQ_IDLE;
      end
      default: begin
        nxt_state = rspc_pkg::RSPC_REQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= rspc_pkg::RSPC_REQ_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // pulse on the first cycle only, so the domain sees one command
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      req_pulse <= 1'b0;
    end else begin
      req_pulse <= set_req && (state_ff == rspc_pkg::RSPC_REQ_IDLE);
    end
  end

  assign pending = (state_ff == rspc_pkg::RSPC_REQ_BUSY);

  property p_ack_clears;
    @(posedge ref_clk) disable iff (!nrst)
      (pending && ack) |=> !pending;
  endproperty
  a_ack_clears: assert property (p_ack_clears)
    else $error("ack not clearing");
endmodule : rspc_req_chan
